// File: cdar_consts.svh
`ifndef CDAR_CONSTS_SVH
`define CDAR_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CDAR_OFS_CAL_DATE   8'h00
`define CDAR_OFS_ALM_DATE   8'h04
`define CDAR_OFS_CTRL       8'h08
`define CDAR_OFS_STATUS     8'h0c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CDAR_YT_HI      31
`define CDAR_YT_LO      28
`define CDAR_YU_HI      27
`define CDAR_YU_LO      24
`define CDAR_MT_BIT     20
`define CDAR_MU_HI      19
`define CDAR_MU_LO      16
`define CDAR_DT_HI      13
`define CDAR_DT_LO      12
`define CDAR_DU_HI      11
`define CDAR_DU_LO      8
`define CDAR_WD_HI      2
`define CDAR_WD_LO      0
`define CDAR_CTRL_RUN   0
`define CDAR_CTRL_LOCK  1
`define CDAR_ST_SYNC    2
`define CDAR_ST_ALMUNS  1
`define CDAR_ST_PEND    0
`define CDAR_ST_DROP    3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CDAR_RST_DATE   32'h0000_0000
`define CDAR_RST_CTRL   2'h1
`define CDAR_RST_FIELDS 22'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CDAR_CLK_PERIOD_NS  50
`define CDAR_SYNC_LEAD_NS   500
`define CDAR_SYNC_TRAIL_NS  200
`define CDAR_LEAD_CYC  ((`CDAR_SYNC_LEAD_NS + `CDAR_CLK_PERIOD_NS - 1) / `CDAR_CLK_PERIOD_NS)
`define CDAR_TRAIL_CYC ((`CDAR_SYNC_TRAIL_NS + `CDAR_CLK_PERIOD_NS - 1) / `CDAR_CLK_PERIOD_NS)
`define CDAR_WIN_W      5

`endif

// File: cdar_pkg.sv
`default_nettype none
package cdar_pkg;

  typedef struct packed {
    logic [3:0] yt;
    logic [3:0] yu;
    logic       mt;
    logic [3:0] mu;
    logic [1:0] dt;
    logic [3:0] du;
    logic [2:0] wd;
  } cdar_date_t;

  typedef enum logic [1:0] {
    CDAR_IDLE  = 2'b00,
    CDAR_LEAD  = 2'b01,
    CDAR_APPLY = 2'b10,
    CDAR_TRAIL = 2'b11
  } cdar_state_t;

endpackage
`default_nettype wire

// File: cdar_date_if.sv
`default_nettype none
interface cdar_date_if;
  import cdar_pkg::*;
  logic        wr;
  logic [31:0] wdata;
  logic        load;
  cdar_date_t  next;
  cdar_date_t  q;

  modport ctl   (output wr, output wdata, output load, output next, input q);
  modport store (input wr, input wdata, input load, input next, output q);
endinterface
`default_nettype wire

// File: cdar_date_store.sv
`include "cdar_consts.svh"
`default_nettype none
module cdar_date_store
  import cdar_pkg::*;
#(
  parameter bit HAS_YEAR = 1'b1
) (
  input  wire logic   i_ref_clk,
  input  wire logic   i_arst_n,
  cdar_date_if.store  bus
);

  // a bus write wins over the calendar advance in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus.q <= cdar_date_t'(`CDAR_RST_FIELDS);
    end else if (bus.wr) begin
      bus.q.yt <= HAS_YEAR ? bus.wdata[`CDAR_YT_HI:`CDAR_YT_LO] : 4'h0;
      bus.q.yu <= HAS_YEAR ? bus.wdata[`CDAR_YU_HI:`CDAR_YU_LO] : 4'h0;
      bus.q.mt <= bus.wdata[`CDAR_MT_BIT];
      bus.q.mu <= bus.wdata[`CDAR_MU_HI:`CDAR_MU_LO];
      bus.q.dt <= bus.wdata[`CDAR_DT_HI:`CDAR_DT_LO];
      bus.q.du <= bus.wdata[`CDAR_DU_HI:`CDAR_DU_LO];
      bus.q.wd <= bus.wdata[`CDAR_WD_HI:`CDAR_WD_LO];
    end else if (bus.load) begin
      bus.q <= bus.next;
    end
  end

endmodule
`default_nettype wire

// File: cdar_win_cnt.sv
`include "cdar_consts.svh"
`default_nettype none
module cdar_win_cnt (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_load,
  input  wire logic [`CDAR_WIN_W-1:0] i_value,
  output logic                        o_last
);

  logic [`CDAR_WIN_W-1:0] count;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count <= '0;
    end else if (i_load) begin
      count <= i_value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  // high in the final cycle of a window that was loaded with n: n cycles long
  assign o_last = (count == `CDAR_WIN_W'(1));

endmodule
`default_nettype wire

// File: cdar_calendar.sv
`include "cdar_consts.svh"
`default_nettype none
module cdar_calendar
  import cdar_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // time-keeping and alarm side, same clock
  input  wire logic        i_day_tick,
  input  wire logic        i_alarm_busy,
  output logic             o_sync_flag,
  output logic             o_alarm_write_unsafe_flag,
  output logic      [31:0] o_calendar_date,
  output logic      [31:0] o_alarm_date
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [`CDAR_WIN_W-1:0] LEAD_CYC  = `CDAR_WIN_W'(`CDAR_LEAD_CYC);
  localparam logic [`CDAR_WIN_W-1:0] TRAIL_CYC = `CDAR_WIN_W'(`CDAR_TRAIL_CYC);

  cdar_date_if cal_if ();
  cdar_date_if alm_if ();

  cdar_state_t            state;
  cdar_state_t            next_state;
  logic [1:0]             ctrl;
  logic                   tick_pending;
  logic                   alarm_unsafe;
  logic                   alarm_drop;
  logic                   win_load;
  logic [`CDAR_WIN_W-1:0] win_value;
  logic                   win_last;
  logic                   wr_cal;
  logic                   wr_alm;
  logic                   wr_ctrl;
  logic                   wr_status;
  logic                   alm_blocked;
  logic [31:0]            cal_word;
  logic [31:0]            alm_word;
  logic [31:0]            status_word;
  logic [31:0]            next_rdata;
  cdar_date_t             cur;
  cdar_date_t             nxt;
  logic [6:0]             day_bin;
  logic [6:0]             last_bin;
  logic [4:0]             month_bin;
  logic                   leap;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // the lock option lets hardware shield the alarm comparator from a
  // careless write; without it the software handshake alone protects it
  assign alm_blocked = ctrl[`CDAR_CTRL_LOCK] & alarm_unsafe;
  assign wr_cal      = i_wr & (i_addr == `CDAR_OFS_CAL_DATE);
  assign wr_alm      = i_wr & (i_addr == `CDAR_OFS_ALM_DATE) & ~alm_blocked;
  assign wr_ctrl     = i_wr & (i_addr == `CDAR_OFS_CTRL);
  assign wr_status   = i_wr & (i_addr == `CDAR_OFS_STATUS);

  // ----------------------------------------------------------------
  // date storage
  // ----------------------------------------------------------------
  assign cal_if.wr    = wr_cal;
  assign cal_if.wdata = i_wdata;
  assign cal_if.load  = (state == CDAR_APPLY);
  assign cal_if.next  = nxt;
  assign alm_if.wr    = wr_alm;
  assign alm_if.wdata = i_wdata;
  assign alm_if.load  = 1'b0;
  assign alm_if.next  = cdar_date_t'(`CDAR_RST_FIELDS);

  cdar_date_store #(
    .HAS_YEAR (1'b1)
  ) u_cal_store (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .bus       (cal_if.store)
  );

  cdar_date_store #(
    .HAS_YEAR (1'b0)
  ) u_alm_store (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .bus       (alm_if.store)
  );

  assign cur = cal_if.q;

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  always_comb begin
    cal_word                               = '0;
    cal_word[`CDAR_YT_HI:`CDAR_YT_LO]      = cur.yt;
    cal_word[`CDAR_YU_HI:`CDAR_YU_LO]      = cur.yu;
    cal_word[`CDAR_MT_BIT]                 = cur.mt;
    cal_word[`CDAR_MU_HI:`CDAR_MU_LO]      = cur.mu;
    cal_word[`CDAR_DT_HI:`CDAR_DT_LO]      = cur.dt;
    cal_word[`CDAR_DU_HI:`CDAR_DU_LO]      = cur.du;
    cal_word[`CDAR_WD_HI:`CDAR_WD_LO]      = cur.wd;
  end

  always_comb begin
    alm_word                               = '0;
    alm_word[`CDAR_MT_BIT]                 = alm_if.q.mt;
    alm_word[`CDAR_MU_HI:`CDAR_MU_LO]      = alm_if.q.mu;
    alm_word[`CDAR_DT_HI:`CDAR_DT_LO]      = alm_if.q.dt;
    alm_word[`CDAR_DU_HI:`CDAR_DU_LO]      = alm_if.q.du;
    alm_word[`CDAR_WD_HI:`CDAR_WD_LO]      = alm_if.q.wd;
  end

  always_comb begin
    status_word                  = '0;
    status_word[`CDAR_ST_SYNC]   = o_sync_flag;
    status_word[`CDAR_ST_ALMUNS] = alarm_unsafe;
    status_word[`CDAR_ST_PEND]   = tick_pending;
    status_word[`CDAR_ST_DROP]   = alarm_drop;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        `CDAR_OFS_CAL_DATE: next_rdata = cal_word;
        `CDAR_OFS_ALM_DATE: next_rdata = alm_word;
        `CDAR_OFS_CTRL:     next_rdata = {30'h0000_0000, ctrl};
        `CDAR_OFS_STATUS:   next_rdata = status_word;
        default:            next_rdata = '0;
      endcase
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // control and status
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= `CDAR_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= i_wdata[`CDAR_CTRL_LOCK:`CDAR_CTRL_RUN];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alarm_unsafe <= 1'b0;
    end else begin
      alarm_unsafe <= i_alarm_busy;
    end
  end

  // sticky record of a refused alarm write; a refusal beats a clear
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alarm_drop <= 1'b0;
    end else if (i_wr && (i_addr == `CDAR_OFS_ALM_DATE) && alm_blocked) begin
      alarm_drop <= 1'b1;
    end else if (wr_status && i_wdata[`CDAR_ST_DROP]) begin
      alarm_drop <= 1'b0;
    end
  end

  // a day tick that lands while an update is under way is kept, not lost
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_pending <= 1'b0;
    end else if (i_day_tick && ctrl[`CDAR_CTRL_RUN]) begin
      tick_pending <= 1'b1;
    end else if (state == CDAR_IDLE) begin
      tick_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // update sequencer
  // ----------------------------------------------------------------
  // the flag rises a lead window before the date moves and stays up a
  // trail window after, so a read that starts with the flag low is safe
  always_comb begin
    next_state = state;
    win_load   = 1'b0;
    win_value  = LEAD_CYC;
    case (state)
      CDAR_IDLE: begin
        if (tick_pending) begin
          next_state = CDAR_LEAD;
          win_load   = 1'b1;
          win_value  = LEAD_CYC;
        end
      end
      CDAR_LEAD: begin
        if (win_last) begin
          next_state = CDAR_APPLY;
        end
      end
      CDAR_APPLY: begin
        next_state = CDAR_TRAIL;
        win_load   = 1'b1;
        win_value  = TRAIL_CYC;
      end
      CDAR_TRAIL: begin
        if (win_last) begin
          next_state = CDAR_IDLE;
        end
      end
      default: begin
        next_state = CDAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= CDAR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sync_flag <= 1'b0;
    end else begin
      o_sync_flag <= (next_state != CDAR_IDLE);
    end
  end

  cdar_win_cnt u_win (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_load    (win_load),
    .i_value   (win_value),
    .o_last    (win_last)
  );

  // ----------------------------------------------------------------
  // next calendar day
  // ----------------------------------------------------------------
  // leap years follow the plain four-year rule over the two-digit year
  always_comb begin
    leap = cur.yt[0] ? ((cur.yu == 4'h2) || (cur.yu == 4'h6))
                     : ((cur.yu == 4'h0) || (cur.yu == 4'h4) || (cur.yu == 4'h8));
  end

  always_comb begin
    month_bin = cur.mt ? (5'h0a + {1'b0, cur.mu}) : {1'b0, cur.mu};
    day_bin   = (7'(cur.dt) * 7'h0a) + {3'h0, cur.du};
    case (month_bin)
      5'h02:   last_bin = leap ? 7'h1d : 7'h1c;
      5'h04:   last_bin = 7'h1e;
      5'h06:   last_bin = 7'h1e;
      5'h09:   last_bin = 7'h1e;
      5'h0b:   last_bin = 7'h1e;
      default: last_bin = 7'h1f;
    endcase
  end

  // out-of-range values written by software roll to the first legal value
  always_comb begin
    nxt    = cur;
    nxt.wd = (cur.wd >= 3'h6) ? 3'h0 : cur.wd + 3'h1;
    if (day_bin >= last_bin) begin
      nxt.dt = 2'h0;
      nxt.du = 4'h1;
      if (month_bin >= 5'h0c) begin
        nxt.mt = 1'b0;
        nxt.mu = 4'h1;
        if (cur.yu >= 4'h9) begin
          nxt.yu = 4'h0;
          nxt.yt = (cur.yt >= 4'h9) ? 4'h0 : cur.yt + 4'h1;
        end else begin
          nxt.yu = cur.yu + 4'h1;
        end
      end else if (cur.mu >= 4'h9) begin
        nxt.mt = 1'b1;
        nxt.mu = 4'h0;
      end else begin
        nxt.mu = cur.mu + 4'h1;
      end
    end else if (cur.du >= 4'h9) begin
      nxt.du = 4'h0;
      nxt.dt = cur.dt + 2'h1;
    end else begin
      nxt.du = cur.du + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // outputs to time keeping and alarm comparator
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_calendar_date           <= `CDAR_RST_DATE;
      o_alarm_date              <= `CDAR_RST_DATE;
      o_alarm_write_unsafe_flag <= 1'b0;
    end else begin
      o_calendar_date           <= cal_word;
      o_alarm_date              <= alm_word;
      o_alarm_write_unsafe_flag <= alarm_unsafe;
    end
  end

endmodule
`default_nettype wire

// File: cdar_calendar_assertions.sv
`include "cdar_consts.svh"
`default_nettype none
module cdar_calendar_assertions (
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [31:0] o_rdata,
  input  wire logic        i_day_tick,
  input  wire logic        i_alarm_busy,
  input  wire logic        o_sync_flag,
  input  wire logic        o_alarm_write_unsafe_flag,
  input  wire logic [31:0] o_calendar_date,
  input  wire logic [31:0] o_alarm_date
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  // ----------------------------------------------------------------
  // field layout and read path
  // ----------------------------------------------------------------
  chk_cal_unused_zero: assert property (
    {o_calendar_date[23:21], o_calendar_date[15:14], o_calendar_date[7:3]} == 10'h000)
    else $error("calendar date unused bits not zero");
  chk_alm_upper_zero: assert property (
    {o_alarm_date[31:21], o_alarm_date[15:14], o_alarm_date[7:3]} == 18'h00000)
    else $error("alarm date unused bits not zero");
  chk_cal_rd_zero: assert property (
    $past(i_rd) && $past(i_addr) == `CDAR_OFS_CAL_DATE |->
      {o_rdata[23:21], o_rdata[15:14], o_rdata[7:3]} == 10'h000)
    else $error("calendar date read shows unused bits");
  chk_alm_rd_zero: assert property (
    $past(i_rd) && $past(i_addr) == `CDAR_OFS_ALM_DATE |-> o_rdata[31:21] == 11'h000)
    else $error("alarm date read shows year bits");
  chk_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");

  // ----------------------------------------------------------------
  // synchronization flags
  // ----------------------------------------------------------------
  chk_unsafe_delay: assert property (
    $past(i_arst_n, 2) && $past(i_arst_n) |->
      o_alarm_write_unsafe_flag == $past(i_alarm_busy, 2))
    else $error("alarm unsafe flag not busy delayed by two");
  chk_sync_hold: assert property (
    $rose(o_sync_flag) |-> o_sync_flag [*8])
    else $error("sync flag window too short");
  chk_sync_fall: assert property (
    $fell(o_sync_flag) |-> $past(o_sync_flag, 8))
    else $error("sync flag fell early");
  // the date may only move inside the flagged window or right after a write
  chk_date_quiet: assert property (
    $changed(o_calendar_date) |-> $past(o_sync_flag) || $past(i_wr) || $past(i_wr, 2))
    else $error("calendar date changed with sync flag low");
endmodule

bind cdar_calendar cdar_calendar_assertions i_chk (
  .i_ref_clk                 (i_ref_clk),
  .i_arst_n                  (i_arst_n),
  .i_addr                    (i_addr),
  .i_wdata                   (i_wdata),
  .i_wr                      (i_wr),
  .i_rd                      (i_rd),
  .o_rdata                   (o_rdata),
  .i_day_tick                (i_day_tick),
  .i_alarm_busy              (i_alarm_busy),
  .o_sync_flag               (o_sync_flag),
  .o_alarm_write_unsafe_flag (o_alarm_write_unsafe_flag),
  .o_calendar_date           (o_calendar_date),
  .o_alarm_date              (o_alarm_date)
);
`default_nettype wire

// File: test_cdar_calendar.sv
`include "cdar_consts.svh"
`default_nettype none
module test_cdar_calendar
  import cdar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        tick  = 1'b0;
  logic        busy  = 1'b0;
  logic [31:0] rdata;
  logic        sync_flag;
  logic        unsafe_flag;
  logic [31:0] cal_date;
  logic [31:0] alm_date;
  logic [31:0] d;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          cycles      = 0;
  // one field at a time, all bits of that field set
  logic [31:0] fld [7] = '{32'hf000_0000, 32'h0f00_0000, 32'h0010_0000, 32'h000f_0000,
                           32'h0000_3000, 32'h0000_0f00, 32'h0000_0007};

  always #25 clk = ~clk;

  cdar_calendar i_dut (
    .i_ref_clk                 (clk),
    .i_arst_n                  (rst_n),
    .i_addr                    (addr),
    .i_wdata                   (wdata),
    .i_wr                      (wr),
    .i_rd                      (rd),
    .o_rdata                   (rdata),
    .i_day_tick                (tick),
    .i_alarm_busy              (busy),
    .o_sync_flag               (sync_flag),
    .o_alarm_write_unsafe_flag (unsafe_flag),
    .o_calendar_date           (cal_date),
    .o_alarm_date              (alm_date)
  );

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data is valid only in the cycle after the strobe, so sample mid-cycle
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values;
    bus_rd(`CDAR_OFS_CAL_DATE, d);
    cmp("cal reset", 32'h0000_0000, d);
    bus_rd(`CDAR_OFS_ALM_DATE, d);
    cmp("alm reset", 32'h0000_0000, d);
    bus_rd(8'h10, d);
    cmp("unmapped", 32'h0000_0000, d);
  endtask

  task automatic test_cal_fields;
    for (int i = 0; i < 7; i++) begin
      bus_wr(`CDAR_OFS_CAL_DATE, fld[i]);
      bus_rd(`CDAR_OFS_CAL_DATE, d);
      cmp("cal field", fld[i], d);
    end
    bus_wr(`CDAR_OFS_CAL_DATE, 32'h9919_3906);
    bus_rd(`CDAR_OFS_CAL_DATE, d);
    cmp("cal max", 32'h9919_3906, d);
    bus_wr(`CDAR_OFS_CAL_DATE, 32'hffff_ffff);
    bus_rd(`CDAR_OFS_CAL_DATE, d);
    cmp("cal ones", 32'hff1f_3f07, d);
    cmp("cal port", 32'hff1f_3f07, cal_date);
  endtask

  task automatic test_alm_fields;
    for (int i = 2; i < 7; i++) begin
      bus_wr(`CDAR_OFS_ALM_DATE, fld[i]);
      bus_rd(`CDAR_OFS_ALM_DATE, d);
      cmp("alm field", fld[i], d);
    end
    bus_wr(`CDAR_OFS_ALM_DATE, 32'hffff_ffff);
    bus_rd(`CDAR_OFS_ALM_DATE, d);
    cmp("alm ones", 32'h001f_3f07, d);
    cmp("alm port", 32'h001f_3f07, alm_date);
  endtask

  task automatic test_day_advance;
    bus_wr(`CDAR_OFS_CAL_DATE, 32'h2403_1403);
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    bus_rd(`CDAR_OFS_STATUS, d);
    cmp("sync set", 32'h0000_0004, d & 32'h0000_0004);
    cmp("sync pin", 32'h0000_0001, {31'h0, sync_flag});
    // a second tick inside the window is held and runs a second update
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    bus_rd(`CDAR_OFS_STATUS, d);
    cmp("tick pending", 32'h0000_0005, d & 32'h0000_0005);
    repeat (40) @(posedge clk);
    bus_rd(`CDAR_OFS_STATUS, d);
    cmp("sync clear", 32'h0000_0000, d & 32'h0000_0004);
    bus_rd(`CDAR_OFS_CAL_DATE, d);
    cmp("cal two days", 32'h2403_1605, d);
  endtask

  task automatic advance_once(input logic [31:0] start);
    bus_wr(`CDAR_OFS_CAL_DATE, start);
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (20) @(posedge clk);
    bus_rd(`CDAR_OFS_CAL_DATE, d);
  endtask

  // month, year and century carries, leap day, and ticks ignored with run off
  task automatic test_day_rollover;
    advance_once(32'h2412_3106);
    cmp("year roll", 32'h2501_0100, d);
    advance_once(32'h2402_2800);
    cmp("leap day", 32'h2402_2901, d);
    advance_once(32'h2502_2800);
    cmp("common feb", 32'h2503_0101, d);
    advance_once(32'h9912_3106);
    cmp("century wrap", 32'h0001_0100, d);
    bus_wr(`CDAR_OFS_CTRL, 32'h0000_0000);
    advance_once(32'h2403_1403);
    cmp("run off", 32'h2403_1403, d);
    bus_wr(`CDAR_OFS_CTRL, 32'h0000_0001);
  endtask

  // with lock set the block refuses alarm writes while the unsafe flag is up
  task automatic test_alarm_unsafe;
    bus_wr(`CDAR_OFS_ALM_DATE, 32'h0012_2506);
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    cmp("unsafe pin", 32'h0000_0001, {31'h0, unsafe_flag});
    bus_wr(`CDAR_OFS_CTRL, 32'h0000_0003);
    bus_wr(`CDAR_OFS_ALM_DATE, 32'h0001_0101);
    bus_rd(`CDAR_OFS_ALM_DATE, d);
    cmp("alm held", 32'h0012_2506, d);
    bus_rd(`CDAR_OFS_STATUS, d);
    cmp("drop flag", 32'h0000_000a, d & 32'h0000_000a);
    bus_wr(`CDAR_OFS_STATUS, 32'h0000_0008);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    cmp("safe pin", 32'h0000_0000, {31'h0, unsafe_flag});
    bus_wr(`CDAR_OFS_ALM_DATE, 32'h0001_0101);
    bus_rd(`CDAR_OFS_ALM_DATE, d);
    cmp("alm written", 32'h0001_0101, d);
    bus_rd(`CDAR_OFS_STATUS, d);
    cmp("drop cleared", 32'h0000_0000, d & 32'h0000_0008);
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    test_reset_values();
    test_cal_fields();
    test_alm_fields();
    test_day_advance();
    test_day_rollover();
    test_alarm_unsafe();
    give_verdict();
  end
endmodule
`default_nettype wire
